// ---- design/emcl_defs.vh ----
// Purpose: Constants of the external memory controller: offsets, fields, resets, timing.
// Assumes: Included by its bare name from the design file.
// Notes: Register offsets are byte addresses inside the register window.
`ifndef EMCL_DEFS_VH
`define EMCL_DEFS_VH

`define EMCL_OFF_BANK_CTRL 8'h00
`define EMCL_OFF_NAND_CTRL 8'h04
`define EMCL_OFF_NAND_TIME 8'h08
`define EMCL_OFF_CLK_CTRL 8'h0c
`define EMCL_OFF_STATUS 8'h10
`define EMCL_MEM_SEL_BIT 16

`define EMCL_BANK_WRITE_FIFO_DISABLE 0
`define EMCL_BANK_CCLK_EN 1
`define EMCL_BANK_BUS32 2
`define EMCL_BANK_SYNC 3
`define EMCL_BANK_FIX 4
`define EMCL_BANK_BURST_HI 7
`define EMCL_BANK_BURST_LO 5
`define EMCL_NAND_WAITEN 0
`define EMCL_NAND_MODE 1

`define EMCL_BANK_RESET 8'h24
`define EMCL_NAND_RESET 2'h0
`define EMCL_TIME_RESET 24'h020201
`define EMCL_DIV_RESET 4'h1

`define EMCL_WAIT_STALL 8'hff
`define EMCL_DIV2 4'h1
`define EMCL_DUMMY_BEATS 2'h2
`define EMCL_FIX_GUARD 2'h2
`define EMCL_FIFO_DEPTH 3'h4
`define EMCL_FIFO_LAST 3'h3
`define EMCL_HOLD_MIN 8'h01

`endif

// ---- design/emcl_top.v ----
// Purpose: External memory controller with AHB-Lite slave, write FIFO and memory clock output.
// Assumes: One clock; external pins resynchronised; single word or narrower AHB transfers.
// Notes: Models the known limits of the controller; bank control bit 4 turns on the fixes.
// Overview of operation
// - Every synchronous burst read is followed by two extra read beats whose data is thrown away.
// - A NAND wait timing of all ones stalls the access forever with no fault, wait enable or not.
// - A NAND read waits out the busy level on the wait input before it samples read data unless setup is zero and hold at most one with the fix off.
// - Continuous clock at divide-by-two plus an asynchronous byte access to a 32-bit bank stops the clock.
// - A stopped clock restarts on any synchronous access or any access other than byte-on-32.
// - With the write FIFO bypassed, an empty event follows every single write.
// - A read arriving during a write is taken but held until the write FIFO is empty.
// - With the FIFO bypassed and the fix off, a read arriving within two cycles of the empty event is corrupted.
`include "emcl_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module emcl_top (
  input wire i_clk,
  input wire i_rst_n,
  input wire i_hsel,
  input wire [31:0] i_haddr,
  input wire [1:0] i_htrans,
  input wire i_hwrite,
  input wire [2:0] i_hsize,
  input wire [31:0] i_hwdata,
  input wire i_hready,
  output reg o_hreadyout,
  output reg [31:0] o_hrdata,
  output reg o_hresp,
  output reg o_mem_clk,
  output reg o_mem_cs_n,
  output reg o_mem_oe_n,
  output reg o_mem_we_n,
  output reg [13:0] o_mem_addr,
  output reg [3:0] o_mem_be_n,
  output reg [31:0] o_mem_data,
  output reg o_mem_data_oe,
  input wire [31:0] i_mem_data,
  input wire i_wait_pin_n
);

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_SETUP = 3'h1;
  localparam [2:0] ST_ACCESS = 3'h2;
  localparam [2:0] ST_HOLD = 3'h3;
  localparam [2:0] ST_DUMMY = 3'h4;
  localparam [2:0] ST_STALL = 3'h5;
  localparam [2:0] ST_DONE = 3'h6;

  // Active-low byte enables from the AHB size and low address bits
  function [3:0] be_n_of;
    input [2:0] size;
    input [1:0] a;
    begin
      case (size)
        3'h0: be_n_of = ~(4'h1 << a);
        3'h1: be_n_of = a[1] ? 4'h3 : 4'hc;
        default: be_n_of = 4'h0;
      endcase
    end
  endfunction

  reg [7:0] bank_reg, dp_addr_reg, tcnt_reg, dummy_total_reg;
  reg [1:0] nand_reg, wr_ptr_reg, rd_ptr_reg, dummy_reg, guard_reg;
  reg [23:0] time_reg;
  reg [3:0] div_reg, req_be_reg, div_cnt_reg;
  reg wait_s1_reg, wait_s2_reg, dp_reg_wr_reg, pend_wr_reg, pend_rd_reg, req_byte_reg;
  reg op_rd_reg, empty_evt_reg, empty_evt_d_reg, corrupt_reg, clk_stop_reg;
  reg [31:0] mdat_s1_reg, mdat_s2_reg, cap_reg;
  reg [13:0] req_addr_reg;
  reg [2:0] cnt_reg, st_reg, beat_reg;
  reg [31:0] fifo_data [0:3];
  reg [13:0] fifo_addr [0:3];
  reg [3:0] fifo_be [0:3];
  reg fifo_byte [0:3];

  wire write_fifo_disable = bank_reg[`EMCL_BANK_WRITE_FIFO_DISABLE];
  wire cclk_en = bank_reg[`EMCL_BANK_CCLK_EN];
  wire bus32 = bank_reg[`EMCL_BANK_BUS32];
  wire sync_mode = bank_reg[`EMCL_BANK_SYNC];
  wire fix_en = bank_reg[`EMCL_BANK_FIX];
  wire [2:0] burst_raw = bank_reg[`EMCL_BANK_BURST_HI:`EMCL_BANK_BURST_LO];
  wire [2:0] burst_len = (burst_raw == 3'h0) ? 3'h1 : burst_raw;
  wire waiten = nand_reg[`EMCL_NAND_WAITEN];
  wire nand_mode = nand_reg[`EMCL_NAND_MODE];
  wire [7:0] t_setup = time_reg[7:0];
  wire [7:0] t_wait = time_reg[15:8];
  wire [7:0] t_hold = time_reg[23:16];
  wire [3:0] div_m1 = (div_reg == 4'h0) ? 4'h0 : div_reg - 4'h1;

  wire addr_ok = i_hsel & i_htrans[1] & i_hready;
  wire is_mem = i_haddr[`EMCL_MEM_SEL_BIT];
  wire mem_idle = (st_reg == ST_IDLE);
  wire fifo_empty = (cnt_reg == 3'h0);
  wire fifo_push = pend_wr_reg & (cnt_reg != `EMCL_FIFO_DEPTH);
  wire fifo_pop = (st_reg == ST_DONE) & ~op_rd_reg;
  wire empty_now = fifo_pop & ~fifo_push & (cnt_reg == 3'h1);
  wire start_wr = mem_idle & ~fifo_empty;
  wire start_rd = mem_idle & fifo_empty & ~pend_wr_reg & pend_rd_reg & (guard_reg == 2'h0);
  wire start_any = start_wr | start_rd;
  wire start_byte = start_wr ? fifo_byte[rd_ptr_reg] : req_byte_reg;
  // Busy is missed with zero setup and short hold unless the fix is on
  wire busy_seen = fix_en | (t_setup != 8'h00) | (t_hold > `EMCL_HOLD_MIN);
  wire observe = nand_mode & (op_rd_reg | waiten) & busy_seen;
  wire clk_run = (cclk_en & ~clk_stop_reg) | (sync_mode & ~mem_idle);

  reg [31:0] reg_rdata;
  always @* begin
    reg_rdata = 32'h0;
    case (i_haddr[7:0])
      `EMCL_OFF_BANK_CTRL: reg_rdata = {24'h0, bank_reg};
      `EMCL_OFF_NAND_CTRL: reg_rdata = {30'h0, nand_reg};
      `EMCL_OFF_NAND_TIME: reg_rdata = {8'h0, time_reg};
      `EMCL_OFF_CLK_CTRL: reg_rdata = {28'h0, div_reg};
      `EMCL_OFF_STATUS: reg_rdata = {13'h0, cnt_reg, dummy_total_reg, 3'h0, corrupt_reg,
        (st_reg == ST_STALL), ~mem_idle, fifo_empty, clk_stop_reg};
      default: reg_rdata = 32'h0;
    endcase
  end

  always @(posedge i_clk) begin
    wait_s1_reg <= i_wait_pin_n;
    wait_s2_reg <= wait_s1_reg;
    mdat_s1_reg <= i_mem_data;
    mdat_s2_reg <= mdat_s1_reg;
    if (fifo_push) begin
      fifo_data[wr_ptr_reg] <= i_hwdata;
      fifo_addr[wr_ptr_reg] <= req_addr_reg;
      fifo_be[wr_ptr_reg] <= req_be_reg;
      fifo_byte[wr_ptr_reg] <= req_byte_reg;
    end
  end

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      bank_reg <= `EMCL_BANK_RESET;
      nand_reg <= `EMCL_NAND_RESET;
      time_reg <= `EMCL_TIME_RESET;
      div_reg <= `EMCL_DIV_RESET;
      o_hreadyout <= 1'b1;
      o_hrdata <= 32'h0;
      o_hresp <= 1'b0;
      o_mem_clk <= 1'b0;
      o_mem_cs_n <= 1'b1;
      o_mem_oe_n <= 1'b1;
      o_mem_we_n <= 1'b1;
      o_mem_addr <= 14'h0;
      o_mem_be_n <= 4'hf;
      o_mem_data <= 32'h0;
      o_mem_data_oe <= 1'b0;
      dp_reg_wr_reg <= 1'b0;
      dp_addr_reg <= 8'h0;
      pend_wr_reg <= 1'b0;
      pend_rd_reg <= 1'b0;
      req_addr_reg <= 14'h0;
      req_be_reg <= 4'hf;
      req_byte_reg <= 1'b0;
      wr_ptr_reg <= 2'h0;
      rd_ptr_reg <= 2'h0;
      cnt_reg <= 3'h0;
      st_reg <= ST_IDLE;
      tcnt_reg <= 8'h0;
      op_rd_reg <= 1'b0;
      beat_reg <= 3'h0;
      dummy_reg <= 2'h0;
      cap_reg <= 32'h0;
      empty_evt_reg <= 1'b0;
      empty_evt_d_reg <= 1'b0;
      guard_reg <= 2'h0;
      corrupt_reg <= 1'b0;
      div_cnt_reg <= 4'h0;
      clk_stop_reg <= 1'b0;
      dummy_total_reg <= 8'h0;
    end else begin
      // Register writes land in the data phase
      dp_reg_wr_reg <= 1'b0;
      if (dp_reg_wr_reg) begin
        case (dp_addr_reg)
          `EMCL_OFF_BANK_CTRL: bank_reg <= i_hwdata[7:0];
          `EMCL_OFF_NAND_CTRL: nand_reg <= i_hwdata[1:0];
          `EMCL_OFF_NAND_TIME: time_reg <= i_hwdata[23:0];
          `EMCL_OFF_CLK_CTRL: div_reg <= i_hwdata[3:0];
          default: ;
        endcase
      end
      // Write FIFO bookkeeping; bypass keeps the bus waiting for the empty event
      if (fifo_push) begin
        wr_ptr_reg <= wr_ptr_reg + 2'h1;
        pend_wr_reg <= 1'b0;
        if (!write_fifo_disable)
          o_hreadyout <= 1'b1;
      end
      if (fifo_pop)
        rd_ptr_reg <= rd_ptr_reg + 2'h1;
      cnt_reg <= cnt_reg + {2'h0, fifo_push} - {2'h0, fifo_pop};
      empty_evt_reg <= empty_now;
      empty_evt_d_reg <= empty_evt_reg;
      if (empty_now & write_fifo_disable & ~pend_wr_reg)
        o_hreadyout <= 1'b1;
      if (guard_reg != 2'h0)
        guard_reg <= guard_reg - 2'h1;
      // Memory clock: stops spuriously, restarts on a qualifying access
      if (clk_run) begin
        if (div_cnt_reg == 4'h0) begin
          o_mem_clk <= ~o_mem_clk;
          div_cnt_reg <= div_m1;
        end else begin
          div_cnt_reg <= div_cnt_reg - 4'h1;
        end
      end else begin
        o_mem_clk <= 1'b0;
        div_cnt_reg <= 4'h0;
      end
      // Access engine
      case (st_reg)
        ST_IDLE: begin
          if (start_any) begin
            op_rd_reg <= ~start_wr;
            o_mem_cs_n <= 1'b0;
            o_mem_addr <= start_wr ? fifo_addr[rd_ptr_reg] : req_addr_reg;
            o_mem_be_n <= start_wr ? fifo_be[rd_ptr_reg] : req_be_reg;
            o_mem_data <= fifo_data[rd_ptr_reg];
            o_mem_data_oe <= start_wr;
            beat_reg <= burst_len;
            if (start_rd)
              pend_rd_reg <= 1'b0;
            if (cclk_en & (div_reg == `EMCL_DIV2) & bus32 & start_byte & ~sync_mode)
              clk_stop_reg <= 1'b1;
            else
              clk_stop_reg <= 1'b0;
            if (t_setup != 8'h00) begin
              st_reg <= ST_SETUP;
              tcnt_reg <= t_setup - 8'h01;
            end else begin
              st_reg <= ST_ACCESS;
              tcnt_reg <= t_wait;
              o_mem_oe_n <= start_wr;
              o_mem_we_n <= ~start_wr;
            end
          end
        end
        ST_SETUP: begin
          if (tcnt_reg == 8'h00) begin
            st_reg <= ST_ACCESS;
            tcnt_reg <= t_wait;
            o_mem_oe_n <= ~op_rd_reg;
            o_mem_we_n <= op_rd_reg;
          end else begin
            tcnt_reg <= tcnt_reg - 8'h01;
          end
        end
        ST_ACCESS: begin
          if (nand_mode & (t_wait == `EMCL_WAIT_STALL)) begin
            st_reg <= ST_STALL;
          end else if (tcnt_reg != 8'h00) begin
            tcnt_reg <= tcnt_reg - 8'h01;
          end else if (observe & ~wait_s2_reg) begin
            tcnt_reg <= 8'h00;
          end else begin
            if (op_rd_reg & (beat_reg == burst_len))
              cap_reg <= mdat_s2_reg;
            if (op_rd_reg & sync_mode & (beat_reg != 3'h1)) begin
              beat_reg <= beat_reg - 3'h1;
              tcnt_reg <= t_wait;
            end else if (op_rd_reg & sync_mode) begin
              st_reg <= ST_DUMMY;
              dummy_reg <= `EMCL_DUMMY_BEATS;
            end else begin
              o_mem_oe_n <= 1'b1;
              o_mem_we_n <= 1'b1;
              st_reg <= (t_hold != 8'h00) ? ST_HOLD : ST_DONE;
              tcnt_reg <= t_hold - 8'h01;
            end
          end
        end
        ST_DUMMY: begin
          // Extra beats are read and dropped
          dummy_reg <= dummy_reg - 2'h1;
          dummy_total_reg <= dummy_total_reg + 8'h01;
          if (dummy_reg == 2'h1) begin
            o_mem_oe_n <= 1'b1;
            st_reg <= ST_DONE;
          end
        end
        ST_HOLD: begin
          if (tcnt_reg == 8'h00)
            st_reg <= ST_DONE;
          else
            tcnt_reg <= tcnt_reg - 8'h01;
        end
        ST_STALL: st_reg <= ST_STALL;
        ST_DONE: begin
          st_reg <= ST_IDLE;
          o_mem_cs_n <= 1'b1;
          o_mem_data_oe <= 1'b0;
          if (op_rd_reg) begin
            o_hrdata <= corrupt_reg ? ~cap_reg : cap_reg;
            o_hreadyout <= 1'b1;
            corrupt_reg <= 1'b0;
          end
        end
        default: st_reg <= ST_IDLE;
      endcase
      // Address phase; placed last so a new request wins over data-phase updates
      if (addr_ok) begin
        if (!is_mem) begin
          dp_reg_wr_reg <= i_hwrite;
          dp_addr_reg <= i_haddr[7:0];
          if (!i_hwrite)
            o_hrdata <= reg_rdata;
        end else begin
          req_addr_reg <= i_haddr[15:2];
          req_be_reg <= be_n_of(i_hsize, i_haddr[1:0]);
          req_byte_reg <= (i_hsize == 3'h0);
          if (i_hwrite) begin
            pend_wr_reg <= 1'b1;
            if (write_fifo_disable | (cnt_reg >= `EMCL_FIFO_LAST))
              o_hreadyout <= 1'b0;
          end else begin
            pend_rd_reg <= 1'b1;
            o_hreadyout <= 1'b0;
            if (write_fifo_disable & (empty_evt_reg | empty_evt_d_reg)) begin
              if (fix_en)
                guard_reg <= `EMCL_FIX_GUARD;
              else
                corrupt_reg <= 1'b1;
            end
          end
        end
      end
    end
  end

endmodule
`default_nettype wire

// ---- tb/emcl_mem_model.sv ----
// Purpose: External memory with a ready/busy line.
// Assumes: Sixteen words; busy starts when select is released.
// Notes: Undriven data toggles every cycle so stale values never pass.
`timescale 1ns/1ps
`default_nettype none
module emcl_mem_model (
  input wire logic i_clk,
  input wire logic i_cs_n,
  input wire logic i_oe_n,
  input wire logic i_we_n,
  input wire logic [13:0] i_addr,
  input wire logic [3:0] i_be_n,
  input wire logic [31:0] i_data,
  input wire logic [7:0] i_busy_len,
  output logic [31:0] o_data,
  output logic o_wait_n
);
  logic [31:0] mem [0:15];
  logic [31:0] last = 32'h0;
  logic [7:0] busy = 8'h0;
  logic cs_q = 1'b1;
  initial for (int i = 0; i < 16; i++) mem[i] = 32'h0;
  assign o_data = (!i_oe_n && busy == 8'h0) ? mem[i_addr[3:0]] : ~last;
  assign o_wait_n = (busy == 8'h0);
  always @(posedge i_clk) begin
    last <= o_data;
    cs_q <= i_cs_n;
    if (i_cs_n && !cs_q)
      busy <= i_busy_len;
    else if (busy != 8'h0)
      busy <= busy - 8'h1;
    if (!i_cs_n && !i_we_n)
      for (int b = 0; b < 4; b++)
        if (!i_be_n[b]) mem[i_addr[3:0]][8*b +: 8] <= i_data[8*b +: 8];
  end
endmodule
`default_nettype wire

// ---- tb/emcl_props.sv ----
// Purpose: Port checker for emcl_top.
// Assumes: Bound to the one controller instance.
// Notes: Watches the controller outputs against bus requests.
`timescale 1ns/1ps
`default_nettype none
module emcl_props (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic i_hready,
  input wire logic o_hreadyout,
  input wire logic [31:0] o_hrdata,
  input wire logic o_hresp,
  input wire logic o_mem_clk,
  input wire logic o_mem_cs_n,
  input wire logic o_mem_oe_n,
  input wire logic o_mem_we_n,
  input wire logic o_mem_data_oe
);
  wire take = i_hsel && i_htrans[1] && i_hready;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  a_resp_always_okay: assert property (o_hresp == 1'b0)
    else $error("response not okay");
  a_read_strobe_sel: assert property (!o_mem_oe_n |-> !o_mem_cs_n)
    else $error("read strobe outside select");
  a_write_strobe_sel: assert property (!o_mem_we_n |-> !o_mem_cs_n && o_mem_data_oe)
    else $error("write strobe without select or drive");
  a_strobes_exclusive: assert property (o_mem_oe_n || o_mem_we_n)
    else $error("read and write strobes together");
  a_mem_read_held: assert property (take && !i_hwrite && i_haddr[16] |=> !o_hreadyout)
    else $error("memory read not held");
  a_reg_no_wait: assert property (take && !i_haddr[16] |=> o_hreadyout)
    else $error("register access waited");
  a_rdata_stands: assert property (!$stable(o_hrdata) |->
      $past(take && !i_hwrite) || $rose(o_hreadyout))
    else $error("read data changed without a read");
  a_reset_idle: assert property (disable iff (1'b0)
      !i_rst_n |=> o_hreadyout && o_mem_cs_n && !o_mem_clk)
    else $error("outputs not idle after reset");
endmodule
bind emcl_top emcl_props u_props (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_hsel(i_hsel),
  .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hready(i_hready),
  .o_hreadyout(o_hreadyout), .o_hrdata(o_hrdata), .o_hresp(o_hresp),
  .o_mem_clk(o_mem_clk), .o_mem_cs_n(o_mem_cs_n), .o_mem_oe_n(o_mem_oe_n),
  .o_mem_we_n(o_mem_we_n), .o_mem_data_oe(o_mem_data_oe));
`default_nettype wire

// ---- tb/tb.sv ----
// Purpose: Self-checking bench for emcl_top.
// Assumes: Bus ready is the controller's own ready.
// Notes: Random memory traffic plus clock, burst, busy and stall corners.
`include "emcl_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_hsel = 1'b0;
  logic i_hwrite = 1'b0;
  logic [31:0] i_haddr = 32'h0;
  logic [31:0] i_hwdata = 32'h0;
  logic [1:0] i_htrans = 2'h0;
  logic [2:0] i_hsize = 3'h2;
  logic [7:0] busy_len = 8'h0;
  wire hrdy, cs_n, oe_n, we_n, wait_n;
  wire [31:0] hrdata, mdo, mdi;
  wire [13:0] maddr;
  wire [3:0] be_n;
  integer failures = 0;
  integer checks_done = 0;
  integer seed = 89149;
  logic [31:0] rd, v, a;
  logic [31:0] ref_mem [0:15];
  always #5 i_clk = ~i_clk;
  emcl_top i_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_hsel(i_hsel), .i_haddr(i_haddr),
    .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(i_hsize), .i_hwdata(i_hwdata),
    .i_hready(hrdy), .o_hreadyout(hrdy), .o_hrdata(hrdata), .o_hresp(), .o_mem_clk(),
    .o_mem_cs_n(cs_n), .o_mem_oe_n(oe_n), .o_mem_we_n(we_n), .o_mem_addr(maddr),
    .o_mem_be_n(be_n), .o_mem_data(mdo), .o_mem_data_oe(), .i_mem_data(mdi),
    .i_wait_pin_n(wait_n));
  emcl_mem_model u_mem (.i_clk(i_clk), .i_cs_n(cs_n), .i_oe_n(oe_n), .i_we_n(we_n),
    .i_addr(maddr), .i_be_n(be_n), .i_data(mdo), .i_busy_len(busy_len),
    .o_data(mdi), .o_wait_n(wait_n));
  task automatic results;
    $display("failures=%0d checks_done=%0d", failures, checks_done);
    if (failures == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s exp=%h got=%h", nm, e, g);
    end
  endtask
  task automatic wait_rdy;
    integer n;
    n = 0;
    @(posedge i_clk);
    while (hrdy !== 1'b1) begin
      n++;
      if (n > 3000) begin
        failures++;
        results;
      end
      @(posedge i_clk);
    end
  endtask
  task automatic ahb(input logic w, input logic [31:0] ad, input logic [2:0] sz,
                     input logic [31:0] wd);
    i_hsel <= 1'b1;
    i_haddr <= ad;
    i_hwrite <= w;
    i_hsize <= sz;
    i_htrans <= 2'h2;
    wait_rdy;
    i_htrans <= 2'h0;
    i_hwdata <= wd;
    wait_rdy;
    rd = hrdata;
  endtask
  task automatic wr(input logic [31:0] ad, input logic [31:0] d);
    ahb(1'b1, ad, 3'h2, d);
  endtask
  task automatic rdchk(input logic [31:0] ad, input logic [31:0] e, input string nm);
    ahb(1'b0, ad, 3'h2, 32'h0);
    cmp(nm, e, rd);
  endtask
  function automatic logic [31:0] maddr_of(input logic [31:0] i);
    return 32'h0001_0000 + {i[29:0], 2'h0};
  endfunction
  initial begin
    for (int i = 0; i < 16; i++) ref_mem[i] = 32'h0;
    repeat (20) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(posedge i_clk);
    rdchk(`EMCL_OFF_BANK_CTRL, `EMCL_BANK_RESET, "bank");
    rdchk(`EMCL_OFF_NAND_CTRL, `EMCL_NAND_RESET, "nand");
    rdchk(`EMCL_OFF_NAND_TIME, `EMCL_TIME_RESET, "time");
    rdchk(`EMCL_OFF_CLK_CTRL, `EMCL_DIV_RESET, "clkdiv");
    wr(32'h1c, 32'hffff_ffff);
    rdchk(32'h1c, 32'h0, "unmapped");
    for (int m = 0; m < 2; m++) begin
      wr(`EMCL_OFF_BANK_CTRL, m ? 32'h35 : 32'h24);
      for (int k = 0; k < 8; k++) begin
        a = $random(seed) & 32'hf;
        v = $random(seed);
        wr(maddr_of(a), v);
        ref_mem[a] = v;
        rdchk(maddr_of(a), v, "mem");
        rdchk(maddr_of(a), v, "mem_again");
      end
      ahb(1'b0, `EMCL_OFF_STATUS, 3'h2, 32'h0);
      cmp("fifo_empty", 32'h1, {31'h0, rd[1]});
    end
    // Bypass on, fixes off: a read right behind a write lands in the empty-event window
    wr(`EMCL_OFF_BANK_CTRL, 32'h25);
    a = $random(seed) & 32'hf;
    v = $random(seed);
    wr(maddr_of(a), v);
    ref_mem[a] = v;
    rdchk(maddr_of(a), ~v, "corrupt");
    rdchk(maddr_of(a), v, "after_corrupt");
    wr(`EMCL_OFF_BANK_CTRL, 32'h6c);
    ahb(1'b0, `EMCL_OFF_STATUS, 3'h2, 32'h0);
    v = rd;
    rdchk(maddr_of(0), ref_mem[0], "burst");
    ahb(1'b0, `EMCL_OFF_STATUS, 3'h2, 32'h0);
    cmp("dummy", {24'h0, v[15:8] + 8'h2}, {24'h0, rd[15:8]});
    wr(`EMCL_OFF_BANK_CTRL, 32'h26);
    wr(`EMCL_OFF_CLK_CTRL, `EMCL_DIV2);
    ahb(1'b1, maddr_of(1) + 32'h1, 3'h0, 32'h0000_ab00);
    ref_mem[1][15:8] = 8'hab;
    // The stop lands when the posted write starts, after the first status read is taken
    repeat (2) ahb(1'b0, `EMCL_OFF_STATUS, 3'h2, 32'h0);
    cmp("clk_stop", 32'h1, {31'h0, rd[0]});
    rdchk(maddr_of(1), ref_mem[1], "after_stop");
    ahb(1'b0, `EMCL_OFF_STATUS, 3'h2, 32'h0);
    cmp("clk_restart", 32'h0, {31'h0, rd[0]});
    wr(`EMCL_OFF_BANK_CTRL, 32'h34);
    wr(`EMCL_OFF_NAND_CTRL, 32'h3);
    wr(`EMCL_OFF_NAND_TIME, 32'h01_02_00);
    busy_len <= 8'h10;
    for (int k = 0; k < 4; k++) begin
      a = $random(seed) & 32'hf;
      rdchk(maddr_of(a), ref_mem[a], "nand_busy");
    end
    wr(`EMCL_OFF_BANK_CTRL, 32'h24);
    wr(`EMCL_OFF_NAND_TIME, 32'h01_02_01);
    rdchk(maddr_of(3), ref_mem[3], "nand_setup");
    busy_len <= 8'h0;
    wr(`EMCL_OFF_NAND_CTRL, 32'h2);
    wr(`EMCL_OFF_NAND_TIME, 32'h01_ff_01);
    i_haddr <= maddr_of(0);
    i_hwrite <= 1'b0;
    i_htrans <= 2'h2;
    @(posedge i_clk);
    i_htrans <= 2'h0;
    repeat (300) @(posedge i_clk);
    cmp("stall", 32'h0, {31'h0, hrdy});
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(posedge i_clk);
    rdchk(`EMCL_OFF_NAND_TIME, `EMCL_TIME_RESET, "time_rst");
    results;
  end
endmodule
`default_nettype wire
